// ===== pkg/sprc_pkg.sv
// constants and register map of the stall prevention ramp control block
`default_nettype none
package sprc_pkg;

    // clock and control update timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int UPDATE_PERIOD_NS = 100_000;
    localparam int UPDATE_CYCLES_I  = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [11:0] UPDATE_CYCLES = 12'(UPDATE_CYCLES_I);

    // data widths
    localparam int DW = 16;
    localparam logic [5:0] DIV_STEPS = 6'h20;

    // current scaling: counts of measured current per percent of rated
    localparam logic [15:0] CUR_PER_PCT = 16'h0028;
    localparam logic [15:0] RATED_CUR   = 16'h0064 * CUR_PER_PCT;
    localparam logic [15:0] SOFT_PCT    = 16'h000F;
    localparam logic [15:0] SOFT_BAND   = SOFT_PCT * CUR_PER_PCT;
    localparam logic [15:0] SOFT_RECIP  = 16'(32'h0001_0000 / 32'(SOFT_BAND));
    localparam logic [15:0] MAX_RATE    = 16'hFFFF;

    // register byte offsets
    localparam logic [7:0] REG_MODE      = 8'h00;
    localparam logic [7:0] REG_ACC_THR   = 8'h04;
    localparam logic [7:0] REG_FLOOR     = 8'h08;
    localparam logic [7:0] REG_DEC_THR   = 8'h0C;
    localparam logic [7:0] REG_BASE_FREQ = 8'h10;
    localparam logic [7:0] REG_STATUS    = 8'h14;
    localparam logic [7:0] REG_EFF_LVL   = 8'h18;

    // mode register field positions
    localparam int ACC_MODE_LSB = 0;
    localparam int DEC_MODE_BIT = 4;

    // status register field positions
    localparam int ST_ACC_HOLD = 0;
    localparam int ST_ACC_SLOW = 1;
    localparam int ST_DEC_HOLD = 2;
    localparam int ST_DEC_SLOW = 3;
    localparam int ST_CP_REG   = 4;

    // setting ranges and reset values
    localparam logic [1:0] ACC_MODE_MAX   = 2'h2;
    localparam logic [1:0] ACC_MODE_RST   = 2'h1;
    localparam logic       DEC_MODE_RST   = 1'b1;
    localparam logic [7:0] ACC_THR_MAX    = 8'hC8;
    localparam logic [7:0] ACC_THR_RST    = 8'h96;
    localparam logic [7:0] FLOOR_MAX      = 8'h64;
    localparam logic [7:0] FLOOR_RST      = 8'h32;
    localparam logic [7:0] DEC_THR_MIN    = 8'h64;
    localparam logic [7:0] DEC_THR_MAX    = 8'hC8;
    localparam logic [7:0] DEC_THR_RST    = 8'h96;
    localparam logic [15:0] BASE_FREQ_RST = 16'h1770;

    // accel supervision modes
    typedef enum logic [1:0] {
        ACC_OFF     = 2'h0,
        ACC_GENERAL = 2'h1,
        ACC_FASTEST = 2'h2
    } sprc_acc_mode_type;

endpackage
`default_nettype wire

// ===== logic/sprc_divider.sv
// restoring divider used to scale a stall level in the constant power range
`timescale 1ns/100ps
`default_nettype none
module sprc_divider
    import sprc_pkg::*;
(
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            resetn,
    // operands
    input  wire logic            start,
    input  wire logic [2*DW-1:0] dividend,
    input  wire logic [DW-1:0]   divisor,
    // result
    output var  logic [2*DW-1:0] quotient,
    output var  logic            done
);

    logic            busy_r;
    logic [5:0]      step_r;
    logic [DW-1:0]   rem_r;
    logic [2*DW-1:0] quo_r;

    wire [DW:0]     remShift = {rem_r, quo_r[2*DW-1]};
    wire            fits     = remShift >= {1'b0, divisor};
    wire [DW:0]     remNxt   = fits ? remShift - {1'b0, divisor} : remShift;
    wire [2*DW-1:0] quoNxt   = {quo_r[2*DW-2:0], fits};
    wire            lastStep = busy_r && (step_r == DIV_STEPS - 6'h01);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
            step_r <= 6'h00;
            rem_r  <= '0;
            quo_r  <= '0;
            done   <= 1'b0;
        end else begin
            done <= lastStep;
            if (start) begin
                busy_r <= 1'b1;
                step_r <= 6'h00;
                rem_r  <= '0;
                quo_r  <= dividend;
            end else if (busy_r) begin
                rem_r  <= remNxt[DW-1:0];
                quo_r  <= quoNxt;
                step_r <= step_r + 6'h01;
                busy_r <= !lastStep;
            end
        end
    end

    assign quotient = quo_r;

endmodule
`default_nettype wire

// ===== logic/sprc_rate_shaper.sv
// shapes one ramp rate against a current level: pass, taper or hold
`timescale 1ns/100ps
`default_nettype none
module sprc_rate_shaper
    import sprc_pkg::*;
(
    // setting
    input  wire logic          enable,
    input  wire logic [DW-1:0] rateIn,
    // measurement against level
    input  wire logic [DW-1:0] current,
    input  wire logic [DW-1:0] level,
    // result
    output var  logic [DW-1:0] rateOut,
    output var  logic          hold,
    output var  logic          slow
);

    wire [DW-1:0] softLevel = (level > SOFT_BAND) ? level - SOFT_BAND
                                                  : '0;
    wire [DW-1:0] margin    = level - current;
    wire [31:0]   frac      = 32'(margin) * 32'(SOFT_RECIP);
    wire [47:0]   prod      = 48'(rateIn) * 48'(frac);

    // margin over the soft band gives a linear taper to zero at the level
    assign hold = enable && (current > level);
    assign slow = enable && !hold && (current > softLevel);

    always_comb begin
        rateOut = rateIn;
        if (hold) begin
            rateOut = '0;
        end else if (slow) begin
            rateOut = prod[31:16];
        end
    end

endmodule
`default_nettype wire

// ===== logic/sprc_top.sv
// stall prevention supervisor for the drive frequency ramp, APB configured
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - accel mode 0..2, reset 1; mode 0 passes the active accel rate.
// - accel mode 1 tapers the rate once current passes level minus 15%.
// - accel mode 1 holds the frequency while current is over the level.
// - accel mode 2 uses the fastest rate, tapered to stay under level.
// - accel level is 0..200 percent of rated current, reset 150.
// - the accel level acts only in accel modes 1 and 2.
// - above base frequency the effective accel level is reduced.
// - the reduced level never goes below the floor, or the set level if that is lower; floor 0..100, reset 50.
// - decel mode 0 or 1, reset 1; mode 0 passes the active decel rate.
// - decel mode 1 tapers the rate once current passes level minus 15%.
// - decel mode 1 holds the frequency while current is over the level.
// - decel level is 100..200 percent, reset 150, acts in mode 1 only.
// - the decel level is reduced the same way, bounded by the floor.
module sprc_top
    import sprc_pkg::*;
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    // ramp generator side
    input  wire logic          driveRunning,
    input  wire logic          rampAccel,
    input  wire logic          rampDecel,
    input  wire logic [DW-1:0] outFreq,
    input  wire logic [DW-1:0] accelRateIn,
    input  wire logic [DW-1:0] decelRateIn,
    output var  logic [DW-1:0] accelRateOut,
    output var  logic [DW-1:0] decelRateOut,
    output var  logic          rateValid,
    // current measurement
    input  wire logic [DW-1:0] outCurrent
);

    // configuration registers
    logic [1:0]    accStallMode_r;
    logic          decStallMode_r;
    logic [7:0]    accStallThr_r;
    logic [7:0]    stallFloor_r;
    logic [7:0]    decStallThr_r;
    logic [15:0]   baseFreq_r;

    // per update state
    logic [11:0]   tickCnt_r;
    logic [DW-1:0] curSample_r;
    logic [DW-1:0] freqSample_r;
    logic          cpRegion_r;
    logic [DW-1:0] effAccLvl_r;
    logic [DW-1:0] effDecLvl_r;
    logic          accHold_r;
    logic          accSlow_r;
    logic          decHold_r;
    logic          decSlow_r;

    // apb decode
    wire access    = psel && penable;
    wire setup     = psel && !penable;
    wire wrAccess  = access && pwrite;
    wire hitMode   = paddr == REG_MODE;
    wire hitAccThr = paddr == REG_ACC_THR;
    wire hitFloor  = paddr == REG_FLOOR;
    wire hitDecThr = paddr == REG_DEC_THR;
    wire hitBase   = paddr == REG_BASE_FREQ;
    wire hitStatus = paddr == REG_STATUS;
    wire hitEff    = paddr == REG_EFF_LVL;
    wire hitCfg    = hitMode || hitAccThr || hitFloor || hitDecThr || hitBase;
    wire mapped    = hitCfg || hitStatus || hitEff;

    // value checks against the documented setting ranges
    wire [1:0] wrAccMode = pwdata[ACC_MODE_LSB +: 2];
    wire       wrDecMode = pwdata[DEC_MODE_BIT];
    wire [7:0] wrByte    = pwdata[7:0];
    wire       upperZero = pwdata[31:8] == 24'h00_0000;
    wire modeOk    = (wrAccMode <= ACC_MODE_MAX)
                  && (pwdata[31:5] == 27'h000_0000)
                  && (pwdata[3:2] == 2'h0);
    wire accThrOk  = upperZero && (wrByte <= ACC_THR_MAX);
    wire floorOk   = upperZero && (wrByte <= FLOOR_MAX);
    wire decThrOk  = upperZero && (wrByte >= DEC_THR_MIN)
                  && (wrByte <= DEC_THR_MAX);
    wire baseOk    = pwdata[31:16] == 16'h0000;
    wire valueOk   = (hitMode && modeOk) || (hitAccThr && accThrOk)
                  || (hitFloor && floorOk) || (hitDecThr && decThrOk)
                  || (hitBase && baseOk);

    // settings may not change while the drive runs, as on the keypad
    wire wrRefused = !hitCfg || !valueOk || driveRunning;
    wire wrCommit  = wrAccess && !wrRefused;

    assign pready  = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && wrRefused));

    // status and read mux
    wire [31:0] statusWord = 32'({cpRegion_r, decSlow_r, decHold_r,
                                  accSlow_r, accHold_r});
    wire [31:0] modeWord   = 32'({decStallMode_r, 2'h0, accStallMode_r});
    wire [31:0] readMux    =
        hitMode   ? modeWord                    :
        hitAccThr ? 32'(accStallThr_r)          :
        hitFloor  ? 32'(stallFloor_r)           :
        hitDecThr ? 32'(decStallThr_r)          :
        hitBase   ? 32'(baseFreq_r)             :
        hitStatus ? statusWord                  :
        hitEff    ? {effDecLvl_r, effAccLvl_r}  :
                    32'h0000_0000;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            accStallMode_r <= ACC_MODE_RST;
            decStallMode_r <= DEC_MODE_RST;
            accStallThr_r  <= ACC_THR_RST;
            stallFloor_r   <= FLOOR_RST;
            decStallThr_r  <= DEC_THR_RST;
            baseFreq_r     <= BASE_FREQ_RST;
        end else if (wrCommit) begin
            if (hitMode) begin
                accStallMode_r <= wrAccMode;
                decStallMode_r <= wrDecMode;
            end
            if (hitAccThr) begin
                accStallThr_r <= wrByte;
            end
            if (hitFloor) begin
                stallFloor_r <= wrByte;
            end
            if (hitDecThr) begin
                decStallThr_r <= wrByte;
            end
            if (hitBase) begin
                baseFreq_r <= pwdata[15:0];
            end
        end
    end

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= readMux;
        end
    end

    wire tick = tickCnt_r == UPDATE_CYCLES - 12'h001;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tickCnt_r <= 12'h000;
        end else begin
            tickCnt_r <= tick ? 12'h000 : tickCnt_r + 12'h001;
        end
    end

    // percent settings scaled to current counts
    wire [DW-1:0] accLvlCnt   = 16'(accStallThr_r) * CUR_PER_PCT;
    wire [DW-1:0] decLvlCnt   = 16'(decStallThr_r) * CUR_PER_PCT;
    wire [DW-1:0] floorCnt    = 16'(stallFloor_r) * CUR_PER_PCT;

    // constant power region above the base frequency
    wire cpRegion = (baseFreq_r != 16'h0000) && (outFreq > baseFreq_r);

    // level times base over output frequency, computed in the background
    wire [2*DW-1:0] accNum = 32'(accLvlCnt) * 32'(baseFreq_r);
    wire [2*DW-1:0] decNum = 32'(decLvlCnt) * 32'(baseFreq_r);
    wire [2*DW-1:0] accQuo;
    wire [2*DW-1:0] decQuo;
    wire            accDone;
    wire            decDone;

    sprc_divider u_acc_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .start    (tick),
        .dividend (accNum),
        .divisor  (freqSample_r),
        .quotient (accQuo),
        .done     (accDone)
    );

    sprc_divider u_dec_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .start    (tick),
        .dividend (decNum),
        .divisor  (freqSample_r),
        .quotient (decQuo),
        .done     (decDone)
    );

    // a level set below the floor is kept, never raised to it
    wire [DW-1:0] accFloor = (floorCnt < accLvlCnt) ? floorCnt : accLvlCnt;
    wire [DW-1:0] decFloor = (floorCnt < decLvlCnt) ? floorCnt : decLvlCnt;

    // effective accel level bounded by the floor
    wire [DW-1:0] accReduced = (accQuo[DW-1:0] < accFloor) ? accFloor
                                                           : accQuo[DW-1:0];
    // effective decel level bounded by the same floor
    wire [DW-1:0] decReduced = (decQuo[DW-1:0] < decFloor) ? decFloor
                                                           : decQuo[DW-1:0];

    // freq captured at tick so the region matches the divider operands
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            freqSample_r <= '0;
            cpRegion_r   <= 1'b0;
        end else if (tick) begin
            freqSample_r <= outFreq;
            cpRegion_r   <= cpRegion;
        end
    end

    // reduced level taken only in the constant power region
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            effAccLvl_r <= '0;
            effDecLvl_r <= '0;
        end else if (accDone && decDone) begin
            effAccLvl_r <= cpRegion_r ? accReduced : accLvlCnt;
            effDecLvl_r <= cpRegion_r ? decReduced : decLvlCnt;
        end
    end

    // accel level applies only in modes 1 and 2
    wire accEnable = rampAccel && (accStallMode_r != ACC_OFF);
    // decel level applies only in mode 1
    wire decEnable = rampDecel && decStallMode_r;
    // fastest mode ignores the configured accel rate
    wire [DW-1:0] accBaseRate = (accStallMode_r == ACC_FASTEST) ? MAX_RATE
                                                               : accelRateIn;

    wire [DW-1:0] accShaped;
    wire [DW-1:0] decShaped;
    wire          accHold;
    wire          accSlow;
    wire          decHold;
    wire          decSlow;

    sprc_rate_shaper u_acc_shape (
        .enable  (accEnable),
        .rateIn  (accBaseRate),
        .current (curSample_r),
        .level   (effAccLvl_r),
        .rateOut (accShaped),
        .hold    (accHold),
        .slow    (accSlow)
    );

    sprc_rate_shaper u_dec_shape (
        .enable  (decEnable),
        .rateIn  (decelRateIn),
        .current (curSample_r),
        .level   (effDecLvl_r),
        .rateOut (decShaped),
        .hold    (decHold),
        .slow    (decSlow)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            curSample_r <= '0;
        end else if (tick) begin
            curSample_r <= outCurrent;
        end
    end

    // outputs refreshed the cycle after the current sample
    logic tickDly_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tickDly_r <= 1'b0;
        end else begin
            tickDly_r <= tick;
        end
    end

    // mode 0 passes the active rates unchanged
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            accelRateOut <= '0;
            decelRateOut <= '0;
            accHold_r    <= 1'b0;
            accSlow_r    <= 1'b0;
            decHold_r    <= 1'b0;
            decSlow_r    <= 1'b0;
            rateValid    <= 1'b0;
        end else begin
            rateValid <= tickDly_r;
            if (tickDly_r) begin
                accelRateOut <= rampAccel ? accShaped : accelRateIn;
                decelRateOut <= decShaped;
                accHold_r    <= accHold;
                accSlow_r    <= accSlow;
                decHold_r    <= decHold;
                decSlow_r    <= decSlow;
            end
        end
    end

endmodule
`default_nettype wire

// ===== test/sprc_load_model.sv
// behavioural power stage whose sensed current follows a load command
`timescale 1ns/100ps
`default_nettype none
module sprc_load_model
    import sprc_pkg::*;
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // load command in percent of rated current
    input  wire logic [7:0]    loadPct,
    // sensed current
    output var  logic [DW-1:0] outCurrent
);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            outCurrent <= '0;
        end else begin
            outCurrent <= 16'(loadPct) * CUR_PER_PCT;
        end
    end
endmodule
`default_nettype wire

// ===== test/sprc_top_properties.sv
// concurrent checks on the ports of the stall prevention block
`timescale 1ns/100ps
`default_nettype none
module sprc_top_checker
    import sprc_pkg::*;
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // apb
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [31:0]   prdata,
    input  wire logic          pready,
    input  wire logic          pslverr,
    // ramp side
    input  wire logic          driveRunning,
    input  wire logic          rampAccel,
    input  wire logic          rampDecel,
    input  wire logic [DW-1:0] outFreq,
    input  wire logic [DW-1:0] accelRateIn,
    input  wire logic [DW-1:0] decelRateIn,
    input  wire logic [DW-1:0] accelRateOut,
    input  wire logic [DW-1:0] decelRateOut,
    input  wire logic          rateValid,
    input  wire logic [DW-1:0] outCurrent
);
    logic [11:0] gapCnt_r;
    logic        seen_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence wr_s(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    // period counter between rate updates
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gapCnt_r <= '0;
            seen_r   <= 1'b0;
        end else if (rateValid) begin
            gapCnt_r <= '0;
            seen_r   <= 1'b1;
        end else begin
            gapCnt_r <= gapCnt_r + 12'h001;
        end
    end

    err_in_access_a: assert property (
        pslverr |-> psel && penable) else $error("error flag outside access");
    pulse_single_a: assert property (
        rateValid |=> !rateValid) else $error("update pulse too long");
    update_period_a: assert property (
        rateValid && seen_r |-> gapCnt_r == UPDATE_CYCLES - 12'h001)
        else $error("update period wrong");
    rates_stable_a: assert property (
        !rateValid |-> $stable(accelRateOut) && $stable(decelRateOut))
        else $error("rate changed between updates");
    accel_pass_a: assert property (
        rateValid && !$past(rampAccel) |->
        accelRateOut == $past(accelRateIn))
        else $error("accel rate not passed while not accelerating");
    acc_range_a: assert property (
        wr_s(REG_ACC_THR) ##0 pwdata > 32'(ACC_THR_MAX) |-> pslverr)
        else $error("accel level above range taken");
    floor_range_a: assert property (
        wr_s(REG_FLOOR) ##0 pwdata > 32'(FLOOR_MAX) |-> pslverr)
        else $error("floor above range taken");
    dec_range_a: assert property (
        wr_s(REG_DEC_THR) ##0 pwdata < 32'(DEC_THR_MIN) |-> pslverr)
        else $error("decel level below range taken");
    mode_range_a: assert property (
        wr_s(REG_MODE) ##0 pwdata[1:0] > ACC_MODE_MAX |-> pslverr)
        else $error("accel mode above range taken");
endmodule

bind sprc_top sprc_top_checker chk_u (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .driveRunning(driveRunning),
    .rampAccel(rampAccel), .rampDecel(rampDecel), .outFreq(outFreq),
    .accelRateIn(accelRateIn), .decelRateIn(decelRateIn),
    .accelRateOut(accelRateOut), .decelRateOut(decelRateOut),
    .rateValid(rateValid), .outCurrent(outCurrent)
);
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the stall prevention ramp control block
`timescale 1ns/100ps
`default_nettype none
module tb
    import sprc_pkg::*;
;
    logic            core_clk     = 1'b0;
    logic            resetn       = 1'b0;
    logic            psel         = 1'b0;
    logic            penable      = 1'b0;
    logic            pwrite       = 1'b0;
    logic [7:0]      paddr        = 8'h00;
    logic [31:0]     pwdata       = 32'h0000_0000;
    logic            driveRunning = 1'b0;
    logic            rampAccel    = 1'b0;
    logic            rampDecel    = 1'b0;
    logic [DW-1:0]   outFreq      = 16'h0000;
    logic [DW-1:0]   accelRateIn  = 16'h1000;
    logic [DW-1:0]   decelRateIn  = 16'h0800;
    logic [7:0]      loadPct      = 8'h00;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [DW-1:0]   accelRateOut;
    logic [DW-1:0]   decelRateOut;
    logic            rateValid;
    logic [DW-1:0]   outCurrent;
    int              errors       = 0;
    int              nCompared    = 0;

    always #25 core_clk = ~core_clk;

    sprc_top dut_u (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .driveRunning(driveRunning),
        .rampAccel(rampAccel), .rampDecel(rampDecel), .outFreq(outFreq),
        .accelRateIn(accelRateIn), .decelRateIn(decelRateIn),
        .accelRateOut(accelRateOut), .decelRateOut(decelRateOut),
        .rateValid(rateValid), .outCurrent(outCurrent)
    );
    sprc_load_model load_u (
        .core_clk(core_clk), .resetn(resetn), .loadPct(loadPct),
        .outCurrent(outCurrent)
    );

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; the request stands until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, d, rd, err);
        check({31'h0, err}, {31'h0, e});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
    endtask

    // two update ticks, so the lagging effective level has settled
    task automatic upd;
        int n;
        repeat (2) begin
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (rateValid !== 1'b1 && n < 3000);
            if (rateValid !== 1'b1) errors++;
        end
    endtask

    function automatic logic [15:0] shape(input logic [15:0] r, c, l);
        if (c > l) return 16'h0000;
        if (c + SOFT_BAND > l) return 16'((32'(r) * 32'((l - c) * SOFT_RECIP)) >> 16);
        return r;
    endfunction

    task automatic run_case(input logic [1:0] am, input logic dm, ra, rd,
                            input logic [7:0] pct, input logic [15:0] f, l);
        logic [15:0] cur;
        logic [15:0] ea;
        logic [15:0] ed;
        logic [4:0]  st;
        logic        ae;
        cur = 16'(pct) * CUR_PER_PCT;
        ae = ra && am != ACC_OFF;
        wr(REG_MODE, {27'h0, dm, 2'h0, am}, 1'b0);
        rampAccel <= ra;
        rampDecel <= rd;
        loadPct <= pct;
        outFreq <= f;
        upd();
        ea = ae ? shape(am == ACC_FASTEST ? MAX_RATE : accelRateIn, cur, l)
                : accelRateIn;
        ed = (rd && dm) ? shape(decelRateIn, cur, l) : decelRateIn;
        st[0] = ae && cur > l;
        st[1] = ae && cur <= l && cur + SOFT_BAND > l;
        st[2] = rd && dm && cur > l;
        st[3] = rd && dm && cur <= l && cur + SOFT_BAND > l;
        st[4] = f > BASE_FREQ_RST;
        check({16'h0, accelRateOut}, {16'h0, ea});
        check({16'h0, decelRateOut}, {16'h0, ed});
        rdc(REG_STATUS, {27'h0, st});
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        rdc(REG_MODE, 32'h0000_0011);
        rdc(REG_ACC_THR, 32'h0000_0096);
        rdc(REG_FLOOR, 32'h0000_0032);
        rdc(REG_DEC_THR, 32'h0000_0096);
        rdc(REG_BASE_FREQ, 32'h0000_1770);
        rdc(8'h1C, 32'h0000_0000);
        $display("test reset values done");
        wr(REG_ACC_THR, 32'h0000_00C9, 1'b1);
        wr(REG_ACC_THR, 32'h0000_0000, 1'b0);
        wr(REG_ACC_THR, 32'h0000_00C8, 1'b0);
        wr(REG_FLOOR, 32'h0000_0065, 1'b1);
        wr(REG_FLOOR, 32'h0000_0064, 1'b0);
        wr(REG_DEC_THR, 32'h0000_0063, 1'b1);
        wr(REG_DEC_THR, 32'h0000_00C8, 1'b0);
        wr(REG_MODE, 32'h0000_0003, 1'b1);
        wr(REG_MODE, 32'h0000_0020, 1'b1);
        wr(REG_STATUS, 32'h0000_0000, 1'b1);
        wr(8'h1C, 32'h0000_0000, 1'b1);
        driveRunning <= 1'b1;
        wr(REG_ACC_THR, 32'h0000_0064, 1'b1);
        driveRunning <= 1'b0;
        rdc(REG_ACC_THR, 32'h0000_00C8);
        rdc(REG_FLOOR, 32'h0000_0064);
        rdc(REG_DEC_THR, 32'h0000_00C8);
        wr(REG_ACC_THR, 32'h0000_0096, 1'b0);
        wr(REG_FLOOR, 32'h0000_0032, 1'b0);
        wr(REG_DEC_THR, 32'h0000_0096, 1'b0);
        $display("test setting ranges done");
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 8'hAF, 16'h0000, 16'h1770);
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 8'h91, 16'h0000, 16'h1770);
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 8'h64, 16'h0000, 16'h1770);
        run_case(2'h2, 1'b1, 1'b1, 1'b0, 8'h91, 16'h0000, 16'h1770);
        run_case(2'h2, 1'b1, 1'b1, 1'b0, 8'h64, 16'h0000, 16'h1770);
        run_case(2'h2, 1'b1, 1'b1, 1'b0, 8'hAF, 16'h0000, 16'h1770);
        run_case(2'h0, 1'b1, 1'b1, 1'b0, 8'hAF, 16'h0000, 16'h1770);
        run_case(2'h1, 1'b1, 1'b0, 1'b1, 8'hAF, 16'h0000, 16'h1770);
        run_case(2'h1, 1'b1, 1'b0, 1'b1, 8'h91, 16'h0000, 16'h1770);
        run_case(2'h1, 1'b0, 1'b0, 1'b1, 8'hAF, 16'h0000, 16'h1770);
        $display("test ramp supervision done");
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 8'h64, 16'h2EE0, 16'h0BB8);
        rdc(REG_EFF_LVL, 32'h0BB8_0BB8);
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 8'h64, 16'hEA60, 16'h07D0);
        rdc(REG_EFF_LVL, 32'h07D0_07D0);
        $display("test constant power done");
        wr(REG_ACC_THR, 32'h0000_0064, 1'b0);
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 8'h64, 16'h0000, 16'h0FA0);
        $display("test lowered level done");
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
